/* File: core/aodr_core.sv */
// diagnostic record of a two-channel analog output module
// How it works
// - type byte low seven bits read 73h, analog output; bit 7 zero.
// - diagnostic bits per channel byte reads constant 08h.
// - channel count byte reads constant 02h.
// - group error bit 0 set while channel group 0 has an error.
// - group error bit 1 set for group 1; bits 7..2 read zero.
// - channel error bit 0 set on a parameter assignment error.
// - channel error bit 3 set on short to ground; others zero.
// - ticker value captured into timestamp when a diagnostic event occurs.
// - microsecond ticker starts from zero at power up.
// - ticker wraps to zero after its 32-bit maximum.
// - no interrupt; error lights channel indicator and is recorded.
// - record 01h serves whole record, record 00h first four bytes.
// - general diagnostic byte bit 3 set while any channel error exists.
`default_nettype none
`include "aodr_params.svh"
module aodr_core (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  input  wire logic [1:0]  param_err_in,
  input  wire logic [1:0]  short_gnd_in,
  input  wire logic        rd_start_in,
  input  wire logic [7:0]  data_record_number_in,
  input  wire logic        rd_next_in,
  output logic [7:0]       rd_data_out,
  output logic             rd_valid_out,
  output logic             rd_last_out,
  output logic             rd_bad_out,
  output logic [1:0]       channel_led_out,
  output logic             group_led_out
);
  logic [1:0]  perr_s1, perr_s2, short_s1, short_s2;
  logic [7:0]  first_channel_errors, second_channel_errors;
  logic [31:0] event_timestamp;
  logic [31:0] us_now;
  logic [7:0]  prev_flags;
  aodr_pkg::aodr_state_e state, next_state;
  aodr_pkg::aodr_idx_t   idx;
  aodr_pkg::aodr_idx_t   last_idx;

  aodr_ticker u_ticker (
    .clk_sys_in   (clk_sys_in),
    .rst_n_in     (rst_n_in),
    .us_count_out (us_now)
  );

  // two-stage synchronisers for the error sense inputs
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      perr_s1  <= 2'h0;
      perr_s2  <= 2'h0;
      short_s1 <= 2'h0;
      short_s2 <= 2'h0;
    end else begin
      perr_s1  <= param_err_in;
      perr_s2  <= perr_s1;
      short_s1 <= short_gnd_in;
      short_s2 <= short_s1;
    end
  end

  wire [7:0] ch0_next = {4'h0, short_s2[0], 2'h0, perr_s2[0]};
  wire [7:0] ch1_next = {4'h0, short_s2[1], 2'h0, perr_s2[1]};
  wire grp0 = |(first_channel_errors & `AODR_ERR_MASK);
  wire grp1 = |(second_channel_errors & `AODR_ERR_MASK);
  wire [7:0] channel_group_errors = {6'h00, grp1, grp0};
  wire any_err = grp0 | grp1;
  wire any_param = first_channel_errors[`AODR_BIT_PARAM]
                 | second_channel_errors[`AODR_BIT_PARAM];
  wire [7:0] general_byte = {any_param, 3'h0, any_err, 3'h0};
  wire [7:0] flags = {ch1_next[3:0], ch0_next[3:0]};
  wire       diag_event = (flags != prev_flags) && (flags != 8'h00);

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      first_channel_errors  <= 8'h00;
      second_channel_errors <= 8'h00;
      prev_flags            <= 8'h00;
      event_timestamp       <= 32'h0000_0000;
    end else begin
      first_channel_errors  <= ch0_next;
      second_channel_errors <= ch1_next;
      prev_flags            <= flags;
      if (diag_event) begin
        event_timestamp <= us_now;
      end
    end
  end

  // indicators driven in place of an interrupt
  assign channel_led_out = {grp1, grp0};
  assign group_led_out   = any_err;

  // record read sequencer
  wire rec_ok = (data_record_number_in == `AODR_REC_FULL)
             || (data_record_number_in == `AODR_REC_SHORT);
  wire [4:0] start_last = (data_record_number_in == `AODR_REC_FULL)
                        ? `AODR_REC_LEN - 5'h01
                        : `AODR_SHORT_LEN - 5'h01;
  wire at_last = (idx == last_idx);

  always_comb begin
    next_state = state;
    case (state)
      aodr_pkg::AODR_IDLE: begin
        if (rd_start_in && rec_ok) begin
          next_state = aodr_pkg::AODR_READ;
        end
      end
      aodr_pkg::AODR_READ: begin
        if (rd_next_in && at_last) begin
          next_state = aodr_pkg::AODR_IDLE;
        end
      end
      default: next_state = aodr_pkg::AODR_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      state      <= aodr_pkg::AODR_IDLE;
      idx        <= 5'h00;
      last_idx   <= 5'h00;
      rd_bad_out <= 1'b0;
    end else begin
      state      <= next_state;
      rd_bad_out <= (state == aodr_pkg::AODR_IDLE) && rd_start_in && !rec_ok;
      if (state == aodr_pkg::AODR_IDLE && rd_start_in && rec_ok) begin
        idx      <= 5'h00;
        last_idx <= start_last;
      end else if (state == aodr_pkg::AODR_READ && rd_next_in) begin
        idx <= idx + 5'h01;
      end
    end
  end

  // byte mux of the record
  logic [7:0] rec_byte;
  always_comb begin
    case (idx)
      `AODR_OFS_GENERAL: rec_byte = general_byte;
      `AODR_OFS_MODINFO: rec_byte = `AODR_MODINFO_VAL;
      `AODR_OFS_CHTYPE:  rec_byte = {1'b0, `AODR_CHTYPE_AOUT};
      `AODR_OFS_NBITS:   rec_byte = `AODR_NBITS_VAL;
      `AODR_OFS_NCH:     rec_byte = `AODR_NCH_VAL;
      `AODR_OFS_GRPERR:  rec_byte = channel_group_errors;
      `AODR_OFS_FIRST_ERR:  rec_byte = first_channel_errors;
      `AODR_OFS_SECOND_ERR: rec_byte = second_channel_errors;
      5'h10:             rec_byte = event_timestamp[7:0];
      5'h11:             rec_byte = event_timestamp[15:8];
      5'h12:             rec_byte = event_timestamp[23:16];
      5'h13:             rec_byte = event_timestamp[31:24];
      default:           rec_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      rd_data_out <= 8'h00;
    end else begin
      rd_data_out <= rec_byte;
    end
  end

  // valid only while the data register holds the byte at the index:
  // low in the cycle after a start or a consume moves the index
  logic rd_valid_q;
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      rd_valid_q <= 1'b0;
      rd_last_out <= 1'b0;
    end else begin
      rd_valid_q  <= (state == aodr_pkg::AODR_READ) && !rd_next_in;
      rd_last_out <= 1'b0;
      if (state == aodr_pkg::AODR_READ && !rd_next_in) begin
        rd_last_out <= at_last;
      end
    end
  end
  assign rd_valid_out = rd_valid_q && (state == aodr_pkg::AODR_READ);

  property p_grp_or;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      channel_group_errors[0]
        == (first_channel_errors[0] || first_channel_errors[3]);
  endproperty
  a_grp_or: assert property (p_grp_or) else $error("group bit0 mismatch");

  property p_short;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      short_gnd_in[0] ##3 short_gnd_in[0] |-> first_channel_errors[3];
  endproperty
  a_short: assert property (p_short) else $error("short not reported");

  property p_param;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      param_err_in[1] [*4] |-> second_channel_errors[0];
  endproperty
  a_param: assert property (p_param) else $error("param not reported");

  property p_grp1;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      channel_group_errors[1]
        == (second_channel_errors[0] || second_channel_errors[3]);
  endproperty
  a_grp1: assert property (p_grp1) else $error("group bit1 mismatch");

  property p_gen;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      general_byte[3] == (first_channel_errors[0] || first_channel_errors[3]
                          || second_channel_errors[0]
                          || second_channel_errors[3]);
  endproperty
  a_gen: assert property (p_gen) else $error("general bit3 wrong");

  property p_stamp;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      diag_event |=> event_timestamp == $past(us_now);
  endproperty
  a_stamp: assert property (p_stamp) else $error("timestamp not taken");

  property p_tick;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      $changed(us_now) |-> us_now == $past(us_now) + 32'h0000_0001;
  endproperty
  a_tick: assert property (p_tick) else $error("ticker step wrong");

  property p_short_rec;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      state == aodr_pkg::AODR_IDLE && rd_start_in
      && data_record_number_in == 8'h00 |=> last_idx == 5'h03;
  endproperty
  a_short_rec: assert property (p_short_rec) else $error("rec 00h len");

  property p_led;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (param_err_in[0] || short_gnd_in[0]) [*4] |-> channel_led_out[0];
  endproperty
  a_led: assert property (p_led) else $error("led mismatch");

  // a read opens with one settling cycle, then the first byte is valid
  sequence s_open;
    state == aodr_pkg::AODR_IDLE && rd_start_in && rec_ok;
  endsequence
  sequence s_first_byte;
    !rd_valid_out ##1 rd_valid_out;
  endsequence
  property p_first;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      s_open |=> s_first_byte;
  endproperty
  a_first: assert property (p_first) else $error("first byte timing");
endmodule
`default_nettype wire

/* File: core/aodr_params.svh */
// offsets, field positions, codes and constants of the diagnostic record
`ifndef AODR_PARAMS_SVH
`define AODR_PARAMS_SVH
// byte offsets within the diagnostic record
`define AODR_OFS_GENERAL      5'h00
`define AODR_OFS_MODINFO      5'h01
`define AODR_OFS_RES_C        5'h02
`define AODR_OFS_DIAG_D       5'h03
`define AODR_OFS_CHTYPE       5'h04
`define AODR_OFS_NBITS        5'h05
`define AODR_OFS_NCH          5'h06
`define AODR_OFS_GRPERR       5'h07
`define AODR_OFS_FIRST_ERR    5'h08
`define AODR_OFS_SECOND_ERR   5'h09
`define AODR_OFS_SPARE_LO     5'h0A
`define AODR_OFS_SPARE_HI     5'h0F
`define AODR_OFS_TS0          5'h10
`define AODR_OFS_TS3          5'h13
`define AODR_REC_LEN          5'h14
`define AODR_SHORT_LEN        5'h04
// record numbers
`define AODR_REC_SHORT        8'h00
`define AODR_REC_FULL         8'h01
// constant contents
`define AODR_CHTYPE_AOUT      7'h73
`define AODR_NBITS_VAL        8'h08
`define AODR_NCH_VAL          8'h02
`define AODR_MODINFO_VAL      8'h15
// field positions
`define AODR_BIT_PARAM        0
`define AODR_BIT_SHORT        3
`define AODR_BIT_GEN_ANYERR   3
`define AODR_BIT_GEN_PARAM    7
`define AODR_ERR_MASK         8'h09
`endif

/* File: core/aodr_pkg.sv */
// types of the diagnostic record block
`default_nettype none
package aodr_pkg;
  typedef enum logic [1:0] {
    AODR_IDLE = 2'b01,
    AODR_READ = 2'b10
  } aodr_state_e;
  typedef logic [4:0] aodr_idx_t;
endpackage
`default_nettype wire

/* File: core/aodr_ticker.sv */
// free-running 32-bit microsecond ticker
`default_nettype none
`include "aodr_params.svh"
module aodr_ticker #(
  parameter int TICK_NS = 1000,
  parameter int CLK_NS  = 5
) (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  output logic [31:0]      us_count_out
);
  localparam int DIV = TICK_NS / CLK_NS;
  logic [15:0] presc;
  wire         tick = (presc == 16'(DIV - 1));

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      presc        <= 16'h0000;
      us_count_out <= 32'h0000_0000;
    end else begin
      presc <= tick ? 16'h0000 : presc + 16'h0001;
      if (tick) begin
        us_count_out <= us_count_out + 32'h0000_0001;
      end
    end
  end
endmodule
`default_nettype wire

/* File: sim/analog_out_diag_record_tb.sv */
// self-checking testbench of the diagnostic record block
`default_nettype none
module analog_out_diag_record_tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [1:0] pe;
    logic [1:0] sg;
    logic [7:0] gen;
    logic [7:0] grp;
    logic [7:0] c0;
    logic [7:0] c1;
  } aodr_row_s;
  localparam aodr_row_s ROWS [0:4] = '{
    '{2'b00, 2'b00, 8'h00, 8'h00, 8'h00, 8'h00},
    '{2'b01, 2'b00, 8'h88, 8'h01, 8'h01, 8'h00},
    '{2'b00, 2'b10, 8'h08, 8'h02, 8'h00, 8'h08},
    '{2'b11, 2'b11, 8'h88, 8'h03, 8'h09, 8'h09},
    '{2'b00, 2'b01, 8'h08, 8'h01, 8'h08, 8'h00}};
  logic       clk_sys_in = 1'b0;
  logic       rst_n_in = 1'b0;
  logic [1:0] param_err_in = 2'b00;
  logic [1:0] short_gnd_in = 2'b00;
  wire logic       rd_start, rd_next, rd_valid, rd_last, rd_bad, grp_led;
  wire logic [7:0] rec_num, rd_data;
  wire logic [1:0] ch_led;
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  int since_rst = 0;
  aodr_core u_aodr_core (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .param_err_in(param_err_in), .short_gnd_in(short_gnd_in),
    .rd_start_in(rd_start), .data_record_number_in(rec_num),
    .rd_next_in(rd_next), .rd_data_out(rd_data), .rd_valid_out(rd_valid),
    .rd_last_out(rd_last), .rd_bad_out(rd_bad),
    .channel_led_out(ch_led), .group_led_out(grp_led));
  aodr_reader u_aodr_reader (.clk_sys_in(clk_sys_in), .rd_data_in(rd_data),
    .rd_valid_in(rd_valid), .rd_last_in(rd_last), .rd_bad_in(rd_bad),
    .rd_start_out(rd_start), .data_record_number_out(rec_num),
    .rd_next_out(rd_next));
  always #2.5 clk_sys_in = ~clk_sys_in;
  task automatic close_out;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk_sys_in) begin
    cycles++;
    since_rst = rst_n_in ? since_rst + 1 : 0;
    if (cycles > 20000) begin
      errors++;
      close_out();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic idle_zero;
    chk({rd_valid, rd_last, rd_bad, grp_led, ch_led, 2'b00}, 8'h00);
    chk(rd_data, 8'h00);
  endtask
  task automatic check_record(input aodr_row_s r, input logic [31:0] ts,
                              input bit tsc);
    logic [7:0] e;
    u_aodr_reader.read_record(8'h01, 0);
    chk(8'(u_aodr_reader.rec_len), 8'h14);
    chk(8'(u_aodr_reader.last_pos), 8'h13);
    for (int i = 0; i < 20; i++) begin
      case (i)
        0: e = r.gen;
        1: e = 8'h15;
        4: e = 8'h73;
        5: e = 8'h08;
        6: e = 8'h02;
        7: e = r.grp;
        8: e = r.c0;
        9: e = r.c1;
        16, 17, 18, 19: e = ts[8*(i-16) +: 8];
        default: e = 8'h00;
      endcase
      if (i < 16 || tsc) chk(u_aodr_reader.rec_buf[i], e);
    end
  endtask
  initial begin
    repeat (9) @(posedge clk_sys_in);
    #1;
    idle_zero();
    @(posedge clk_sys_in);
    #1;
    rst_n_in = 1'b1;
    check_record(ROWS[0], 32'h0000_0000, 1'b1);
    while (since_rst < 2100) @(posedge clk_sys_in);
    #1;
    param_err_in = 2'b01;
    repeat (8) @(posedge clk_sys_in);
    check_record(ROWS[1], 32'h0000_000A, 1'b1);
    foreach (ROWS[i]) begin
      param_err_in = ROWS[i].pe;
      short_gnd_in = ROWS[i].sg;
      repeat (8) @(posedge clk_sys_in);
      #1;
      chk({6'h00, ch_led}, {6'h00, ROWS[i].pe | ROWS[i].sg});
      chk({7'h00, grp_led}, {7'h00, |(ROWS[i].pe | ROWS[i].sg)});
      check_record(ROWS[i], 32'h0, 1'b0);
    end
    u_aodr_reader.read_record(8'h00, 3);
    chk(8'(u_aodr_reader.rec_len), 8'h04);
    chk(8'(u_aodr_reader.last_pos), 8'h03);
    chk(u_aodr_reader.rec_buf[0], 8'h08);
    chk(u_aodr_reader.rec_buf[1], 8'h15);
    u_aodr_reader.read_record(8'h02, 0);
    chk({7'h00, u_aodr_reader.bad_seen}, 8'h01);
    chk(8'(u_aodr_reader.rec_len), 8'h00);
    short_gnd_in = 2'b00;
    rst_n_in = 1'b0;
    repeat (10) @(posedge clk_sys_in);
    #1;
    idle_zero();
    rst_n_in = 1'b1;
    check_record(ROWS[0], 32'h0000_0000, 1'b1);
    while (since_rst < 300) @(posedge clk_sys_in);
    #1;
    param_err_in = 2'b01;
    repeat (8) @(posedge clk_sys_in);
    check_record(ROWS[1], 32'h0000_0001, 1'b1);
    close_out();
  end
endmodule
`default_nettype wire

/* File: sim/aodr_reader.sv */
// far-side reader model: fetches one diagnostic record byte by byte
`default_nettype none
module aodr_reader (
  input  wire logic       clk_sys_in,
  input  wire logic [7:0] rd_data_in,
  input  wire logic       rd_valid_in,
  input  wire logic       rd_last_in,
  input  wire logic       rd_bad_in,
  output logic            rd_start_out,
  output logic [7:0]      data_record_number_out,
  output logic            rd_next_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] rec_buf [0:31];
  int         rec_len;
  int         last_pos;
  logic       bad_seen;
  initial begin
    rd_start_out = 1'b0;
    rd_next_out = 1'b0;
    data_record_number_out = 8'h00;
  end
  // gap adds idle cycles before each consume to model a slow reader
  task automatic read_record(input logic [7:0] rec, input int gap);
    int t;
    rec_len = 0;
    last_pos = -1;
    bad_seen = 1'b0;
    @(posedge clk_sys_in);
    #1;
    rd_start_out = 1'b1;
    data_record_number_out = rec;
    @(posedge clk_sys_in);
    #1;
    rd_start_out = 1'b0;
    data_record_number_out = ~rec;
    for (t = 0; t < 3; t++) begin
      bad_seen = bad_seen | (rd_bad_in === 1'b1);
      @(posedge clk_sys_in);
      #1;
    end
    while (!bad_seen && rec_len < 32 && last_pos < 0) begin
      t = 0;
      while (rd_valid_in !== 1'b1 && t < 50) begin
        @(posedge clk_sys_in);
        #1;
        t++;
      end
      if (rd_valid_in !== 1'b1) break;
      rec_buf[rec_len] = rd_data_in;
      if (rd_last_in === 1'b1) last_pos = rec_len;
      rec_len++;
      repeat (gap) @(posedge clk_sys_in);
      #1;
      rd_next_out = 1'b1;
      @(posedge clk_sys_in);
      #1;
      rd_next_out = 1'b0;
      repeat (2) @(posedge clk_sys_in);
      #1;
    end
  endtask
endmodule
`default_nettype wire
